// file: design/scl_mode_decode.sv
// Decoder from operating-mode strap code to control and advertisement defaults
`timescale 1ns/1ns
module scl_mode_decode
	import scl_pkg::*;
(
	input wire logic [2:0] mode_i,
	output logic [3:0] ctrl_bits_o,
	output logic [3:0] adv_bits_o,
	output logic crs_on_tx_o
);
	// Control bits are ordered speed, autoneg, power-down, duplex
	always_comb begin
		ctrl_bits_o = 4'h0;
		adv_bits_o = 4'h0;
		crs_on_tx_o = 1'b0;
		unique case (scl_mode_t'(mode_i))
			SCL_M_10_HALF: begin
				ctrl_bits_o = 4'h0;
			end
			SCL_M_10_FULL: begin
				ctrl_bits_o = 4'h1;
			end
			SCL_M_100_HALF: begin
				ctrl_bits_o = 4'h8;
				crs_on_tx_o = 1'b1;
			end
			SCL_M_100_FULL: begin
				ctrl_bits_o = 4'h9;
			end
			SCL_M_AN_100_HALF: begin
				ctrl_bits_o = 4'hc;
				adv_bits_o = 4'h4;
				crs_on_tx_o = 1'b1;
			end
			SCL_M_REPEATER: begin
				ctrl_bits_o = 4'hc;
				adv_bits_o = 4'h4;
			end
			SCL_M_POWER_DOWN: begin
				// Power-down bit set; speed and autoneg left off
				ctrl_bits_o = 4'h2;
			end
			SCL_M_ALL_CAPABLE: begin
				// Don't-care bits resolved to 1 (100 Mb, full duplex)
				ctrl_bits_o = 4'hd;
				adv_bits_o = 4'hf;
				crs_on_tx_o = 1'b1;
			end
		endcase
	end
endmodule : scl_mode_decode

// file: design/scl_strap_latch.sv
// Strap capture, decoded defaults and management registers over APB
`timescale 1ns/1ns
`include "scl_consts.svh"
// Overview of operation
// - Straps captured at power-on reset and at release of the pin reset.
// - Unconnected straps resolve to defined defaults via pull resistors at pins.
// - Three address strap levels stored at reset end; default all zeros.
// - Management frames answered only when their address matches the stored one.
// - Stored address seeds the transmit scrambler.
// - Straps give addresses 0 to 7; larger ones written later by software.
// - Address bits sampled on rx error, rx clock and rx data 3.
// - Pin reset release loads control bits from mode straps, then configures logic.
// - Soft reset keeps register values unless leaving power-down; straps are ignored.
// - Codes 000 to 011 force 10/100 half/full with auto-negotiation off.
// - Forced 100 half: carrier sense on tx and rx; full: rx only.
// - Code 100 enables auto-negotiation advertising 100 half only.
// - Code 101 is repeater mode; carrier sense on receive only.
// - Code 111 enables auto-negotiation advertising all abilities.
// - Mode bits sampled on rx data 0, rx data 1 and collision pin.
module scl_strap_latch
	import scl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic pin_reset_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Strap-shared receive pins: input, output, output enable
	input wire logic rx_err_pin_i,
	input wire logic rx_clk_pin_i,
	input wire logic [3:0] rx_data_pin_i,
	input wire logic col_pin_i,
	output logic rx_err_pin_o,
	output logic rx_clk_pin_o,
	output logic [3:0] rx_data_pin_o,
	output logic col_pin_o,
	output logic rx_pins_oe_o,
	// Receive-side values driven onto the pins once running
	input wire logic rx_err_core_i,
	input wire logic rx_clk_core_i,
	input wire logic [3:0] rx_data_core_i,
	input wire logic col_core_i,
	// Management frame address check
	input wire logic [4:0] frame_address_i,
	output logic frame_match_o,
	// Configuration outputs to the 10/100 logic
	output logic [4:0] scrambler_seed_o,
	output logic speed_100_o,
	output logic autoneg_en_o,
	output logic full_duplex_o,
	output logic power_down_o,
	output logic [3:0] advertise_o,
	output logic crs_on_tx_o,
	output logic repeater_o,
	output logic config_valid_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	scl_state_t state;
	scl_state_t next_state;
	logic [4:0] mgmt_address;
	logic [4:0] next_mgmt_address;
	logic [2:0] mode_field;
	logic [2:0] next_mode_field;
	logic [3:0] ctrl_bits;
	logic [3:0] next_ctrl_bits;
	logic [3:0] adv_bits;
	logic [3:0] next_adv_bits;
	logic crs_tx;
	logic next_crs_tx;
	logic [3:0] soft_count;
	logic [3:0] next_soft_count;
	logic pin_reset_n_q;
	logic [31:0] next_prdata;
	logic [3:0] dec_ctrl;
	logic [3:0] dec_adv;
	logic dec_crs_tx;
	logic [2:0] strap_mode;
	logic [4:0] strap_address;
	logic apb_write;
	logic apb_read;
	logic addr_hit;

	function automatic logic scl_decode_hit(input logic [11:0] addr);
		scl_decode_hit = (addr == `SCL_ADDR_CTRL) || (addr == `SCL_ADDR_ADV) ||
			(addr == `SCL_ADDR_SPECIAL) || (addr == `SCL_ADDR_STATUS);
	endfunction : scl_decode_hit

	// ****************************************************************
	// Strap sampling on shared pins
	// ****************************************************************
	// Pins sample only while the pad drivers are off, so own drive never loops back
	assign strap_address = {2'b00, rx_data_pin_i[3], rx_clk_pin_i, rx_err_pin_i};
	assign strap_mode = {col_pin_i, rx_data_pin_i[1], rx_data_pin_i[0]};

	// Soft reset restores the stored mode field, never the pins
	scl_mode_decode scl_mode_decode_inst (
		.mode_i(state == SCL_S_SOFT ? mode_field : strap_mode),
		.ctrl_bits_o(dec_ctrl),
		.adv_bits_o(dec_adv),
		.crs_on_tx_o(dec_crs_tx)
	);

	assign apb_write = psel_i && penable_i && pwrite_i;
	// Read data registers at the setup edge so it stands through the whole access phase
	assign apb_read = psel_i && !penable_i && !pwrite_i;
	assign addr_hit = scl_decode_hit(paddr_i);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		next_state = state;
		next_mgmt_address = mgmt_address;
		next_mode_field = mode_field;
		next_ctrl_bits = ctrl_bits;
		next_adv_bits = adv_bits;
		next_crs_tx = crs_tx;
		next_soft_count = soft_count;
		unique case (state)
			SCL_S_RESET: begin
				// Hold while the pin reset is low; straps are sampled at release
				if (pin_reset_n_q) begin
					next_state = SCL_S_CAPTURE;
				end
			end
			SCL_S_CAPTURE: begin
				next_mgmt_address = strap_address;
				next_mode_field = strap_mode;
				next_ctrl_bits = dec_ctrl;
				next_adv_bits = dec_adv;
				next_crs_tx = dec_crs_tx;
				next_state = SCL_S_RUN;
			end
			SCL_S_RUN: begin
				if (apb_write && paddr_i == `SCL_ADDR_CTRL) begin
					// Software overrides strap defaults
					next_ctrl_bits = {pwdata_i[`SCL_CTRL_SPEED], pwdata_i[`SCL_CTRL_AUTONEG],
						pwdata_i[`SCL_CTRL_POWER_DOWN], pwdata_i[`SCL_CTRL_DUPLEX]};
					if (pwdata_i[`SCL_CTRL_SOFT_RESET]) begin
						next_soft_count = `SCL_SOFT_RESET_CYCLES;
						next_state = SCL_S_SOFT;
					end
				end
				if (apb_write && paddr_i == `SCL_ADDR_ADV) begin
					next_adv_bits = pwdata_i[`SCL_ADV_LSB +: 4];
				end
				if (apb_write && paddr_i == `SCL_ADDR_SPECIAL) begin
					next_mode_field = pwdata_i[`SCL_SPECIAL_MODE_LSB +: 3];
					next_mgmt_address = pwdata_i[`SCL_SPECIAL_ADDR_LSB +: 5];
				end
			end
			SCL_S_SOFT: begin
				// Registers kept; only leaving power-down reloads from the mode field
				if (ctrl_bits[1] && mode_field != SCL_M_POWER_DOWN) begin
					next_ctrl_bits = dec_ctrl;
					next_adv_bits = dec_adv;
					next_crs_tx = dec_crs_tx;
				end
				next_soft_count = soft_count - 4'h1;
				if (soft_count == 4'h1) begin
					next_state = SCL_S_RUN;
				end
			end
		endcase
		if (!pin_reset_n_q) begin
			next_state = SCL_S_RESET;
		end
	end

	always_comb begin
		next_prdata = 32'h0;
		if (apb_read) begin
			unique case (paddr_i)
				`SCL_ADDR_CTRL: begin
					next_prdata[`SCL_CTRL_SPEED] = ctrl_bits[3];
					next_prdata[`SCL_CTRL_AUTONEG] = ctrl_bits[2];
					next_prdata[`SCL_CTRL_POWER_DOWN] = ctrl_bits[1];
					next_prdata[`SCL_CTRL_DUPLEX] = ctrl_bits[0];
					next_prdata[`SCL_CTRL_SOFT_RESET] = (state == SCL_S_SOFT);
				end
				`SCL_ADDR_ADV: begin
					next_prdata[`SCL_ADV_LSB +: 4] = adv_bits;
				end
				`SCL_ADDR_SPECIAL: begin
					next_prdata[`SCL_SPECIAL_MODE_LSB +: 3] = mode_field;
					next_prdata[`SCL_SPECIAL_ADDR_LSB +: 5] = mgmt_address;
				end
				`SCL_ADDR_STATUS: begin
					next_prdata[1:0] = state;
				end
				default: begin
					next_prdata = 32'h0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= SCL_S_RESET;
			mgmt_address <= `SCL_ADDR_DEFAULT;
			mode_field <= `SCL_MODE_DEFAULT;
			ctrl_bits <= 4'h0;
			adv_bits <= 4'h0;
			crs_tx <= 1'b0;
			soft_count <= 4'h0;
			pin_reset_n_q <= 1'b0;
			prdata_o <= 32'h0;
		end else begin
			state <= next_state;
			mgmt_address <= next_mgmt_address;
			mode_field <= next_mode_field;
			ctrl_bits <= next_ctrl_bits;
			adv_bits <= next_adv_bits;
			crs_tx <= next_crs_tx;
			soft_count <= next_soft_count;
			pin_reset_n_q <= pin_reset_n_i;
			prdata_o <= next_prdata;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Zero-wait slave; prdata registers at setup so it is valid in access
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !addr_hit;

	logic running;
	assign running = (state == SCL_S_RUN);
	// Unusable while the power-down code and the power-down bit both hold, so config stays invalid
	assign config_valid_o = running && !(mode_field == SCL_M_POWER_DOWN && ctrl_bits[1]);
	assign frame_match_o = config_valid_o && (frame_address_i == mgmt_address);
	assign scrambler_seed_o = mgmt_address;
	assign speed_100_o = ctrl_bits[3];
	assign autoneg_en_o = ctrl_bits[2];
	assign power_down_o = ctrl_bits[1];
	assign full_duplex_o = ctrl_bits[0];
	assign advertise_o = adv_bits;
	assign crs_on_tx_o = crs_tx;
	assign repeater_o = (mode_field == SCL_M_REPEATER);

	// Pads stay inputs until the straps have been taken
	assign rx_pins_oe_o = running || state == SCL_S_SOFT;
	assign rx_err_pin_o = rx_pins_oe_o & rx_err_core_i;
	assign rx_clk_pin_o = rx_pins_oe_o & rx_clk_core_i;
	assign rx_data_pin_o = rx_pins_oe_o ? rx_data_core_i : 4'h0;
	assign col_pin_o = rx_pins_oe_o & col_core_i;
endmodule : scl_strap_latch

// file: inc/scl_consts.svh
// Offsets, field positions, reset values and timing counts of the strap latch
`ifndef SCL_CONSTS_SVH
`define SCL_CONSTS_SVH
// ****************************************************************
// Register byte addresses
// ****************************************************************
`define SCL_ADDR_CTRL 12'h000
`define SCL_ADDR_ADV 12'h004
`define SCL_ADDR_SPECIAL 12'h008
`define SCL_ADDR_STATUS 12'h00c
// ****************************************************************
// Control, advertisement and special register fields
// ****************************************************************
`define SCL_CTRL_SOFT_RESET 15
`define SCL_CTRL_SPEED 13
`define SCL_CTRL_AUTONEG 12
`define SCL_CTRL_POWER_DOWN 11
`define SCL_CTRL_DUPLEX 8
`define SCL_ADV_LSB 5
`define SCL_SPECIAL_MODE_LSB 5
`define SCL_SPECIAL_ADDR_LSB 0
// ****************************************************************
// Reset values and timing
// ****************************************************************
`define SCL_ADDR_DEFAULT 5'h00
`define SCL_MODE_DEFAULT 3'h7
`define SCL_SOFT_RESET_CYCLES 4'h4
`endif

// file: inc/scl_pkg.sv
// Types shared by the strap latch modules
package scl_pkg;
	typedef enum logic [2:0] {
		SCL_M_10_HALF = 3'b000,
		SCL_M_10_FULL = 3'b001,
		SCL_M_100_HALF = 3'b010,
		SCL_M_100_FULL = 3'b011,
		SCL_M_AN_100_HALF = 3'b100,
		SCL_M_REPEATER = 3'b101,
		SCL_M_POWER_DOWN = 3'b110,
		SCL_M_ALL_CAPABLE = 3'b111
	} scl_mode_t;
	typedef enum logic [1:0] {
		SCL_S_RESET = 2'b00,
		SCL_S_CAPTURE = 2'b01,
		SCL_S_RUN = 2'b10,
		SCL_S_SOFT = 2'b11
	} scl_state_t;
endpackage : scl_pkg

// file: testbench/scl_board_model.sv
// Board straps and pad wiring on the strap-shared receive pins
`timescale 1ns/1ns
module scl_board_model(
	input wire logic float_i,
	input wire logic [2:0] addr_i,
	input wire logic [2:0] mode_i,
	input wire logic oe_i,
	input wire logic pad_err_i,
	input wire logic pad_clk_i,
	input wire logic [3:0] pad_data_i,
	input wire logic pad_col_i,
	output logic err_o,
	output logic clk_o,
	output logic [3:0] data_o,
	output logic col_o
);
	logic [2:0] a;
	logic [2:0] m;
	// Floating straps fall back to the pull levels
	assign a = float_i ? 3'h0 : addr_i;
	assign m = float_i ? 3'h7 : mode_i;
	// Board levels win only while the device leaves the pads alone
	assign err_o = oe_i ? pad_err_i : a[0];
	assign clk_o = oe_i ? pad_clk_i : a[1];
	assign data_o = oe_i ? pad_data_i : {a[2], 1'b0, m[1], m[0]};
	assign col_o = oe_i ? pad_col_i : m[2];
endmodule : scl_board_model

// file: testbench/scl_strap_latch_bench.sv
// Self-checking bench of the strap latch
`timescale 1ns/1ns
module scl_strap_latch_bench;
	import scl_pkg::*;
	logic clk_i = 1'b0, rst_n_i = 1'b0, pin_reset_n_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, rx_err_pin_i, rx_clk_pin_i, col_pin_i, rx_err_pin_o, rx_clk_pin_o, col_pin_o, err;
	logic rx_pins_oe_o, frame_match_o, speed_100_o, autoneg_en_o, full_duplex_o, power_down_o, crs_on_tx_o;
	logic repeater_o, config_valid_o, rx_err_core_i = 1'b1, rx_clk_core_i = 1'b0, col_core_i = 1'b1, strap_float = 1'b1;
	logic [3:0] rx_data_pin_i, rx_data_pin_o, advertise_o, rx_data_core_i = 4'ha;
	logic [4:0] frame_address_i = 5'h00, scrambler_seed_o;
	logic [2:0] strap_addr = 3'h0, strap_mode = 3'h0;
	int fails = 0, samples_checked = 0;
	always #5 clk_i = ~clk_i;
	scl_strap_latch scl_strap_latch_inst(.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_reset_n_i(pin_reset_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_err_pin_i(rx_err_pin_i),
		.rx_clk_pin_i(rx_clk_pin_i), .rx_data_pin_i(rx_data_pin_i), .col_pin_i(col_pin_i),
		.rx_err_pin_o(rx_err_pin_o), .rx_clk_pin_o(rx_clk_pin_o), .rx_data_pin_o(rx_data_pin_o),
		.col_pin_o(col_pin_o), .rx_pins_oe_o(rx_pins_oe_o), .rx_err_core_i(rx_err_core_i),
		.rx_clk_core_i(rx_clk_core_i), .rx_data_core_i(rx_data_core_i), .col_core_i(col_core_i),
		.frame_address_i(frame_address_i), .frame_match_o(frame_match_o), .scrambler_seed_o(scrambler_seed_o),
		.speed_100_o(speed_100_o), .autoneg_en_o(autoneg_en_o), .full_duplex_o(full_duplex_o),
		.power_down_o(power_down_o), .advertise_o(advertise_o), .crs_on_tx_o(crs_on_tx_o),
		.repeater_o(repeater_o), .config_valid_o(config_valid_o));
	scl_board_model scl_board_model_inst(.float_i(strap_float), .addr_i(strap_addr), .mode_i(strap_mode),
		.oe_i(rx_pins_oe_o), .pad_err_i(rx_err_pin_o), .pad_clk_i(rx_clk_pin_o), .pad_data_i(rx_data_pin_o),
		.pad_col_i(col_pin_o), .err_o(rx_err_pin_i), .clk_o(rx_clk_pin_i), .data_o(rx_data_pin_i), .col_o(col_pin_i));
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	// Response and read data are taken at the edge that samples pready high, then released
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		err = pslverr_o;
		rd = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task wait_oe;
		int n;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (rx_pins_oe_o !== 1'b1 && n < 20);
		chk("oe", 1, rx_pins_oe_o);
	endtask : wait_oe
	task wait_status;
		int n;
		n = 0;
		do begin
			apb(1'b0, 12'h00c, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b10 && n < 10);
		chk("status", 2, rd[1:0]);
	endtask : wait_status
	task run_strap(input logic [2:0] a, input logic [2:0] m);
		@(posedge clk_i);
		strap_float <= 1'b0;
		strap_addr <= a;
		strap_mode <= m;
		pin_reset_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		pin_reset_n_i <= 1'b1;
		wait_oe;
	endtask : run_strap
	function automatic logic [3:0] exp_ctrl(input int m);
		case (m)
			1: return 4'b0010;
			2: return 4'b1000;
			3: return 4'b1010;
			4, 5: return 4'b1100;
			6: return 4'b0001;
			7: return 4'b1110;
			default: return 4'b0000;
		endcase
	endfunction : exp_ctrl
	task t_modes;
		for (int m = 0; m < 8; m++) begin
			run_strap(3'(7 - m), 3'(m));
			chk("ctrl", exp_ctrl(m), {speed_100_o, autoneg_en_o, full_duplex_o, power_down_o});
			chk("seed", 32'(7 - m), scrambler_seed_o);
			chk("valid", m != 6, config_valid_o);
			chk("repeater", m == 5, repeater_o);
			if (m > 1 && m < 6) chk("crs", m % 2 == 0, crs_on_tx_o);
			if (m > 3 && m != 6) chk("adv", m == 7 ? 15 : 4, advertise_o);
			chk("pads", 7'h55, {rx_data_pin_o, rx_err_pin_o, rx_clk_pin_o, col_pin_o});
		end
		$display("modes done");
	endtask : t_modes
	task t_match;
		run_strap(3'h5, 3'h3);
		for (int a = 3; a < 7; a++) begin
			@(posedge clk_i);
			frame_address_i <= 5'(a);
			@(negedge clk_i);
			chk("match", a == 5, frame_match_o);
		end
		apb(1'b1, 12'h008, 32'h00000073);
		apb(1'b0, 12'h008, 32'h0);
		chk("special", 8'h73, rd[7:0]);
		@(posedge clk_i);
		frame_address_i <= 5'h13;
		@(negedge clk_i);
		chk("match", 1, frame_match_o);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 1, err);
		$display("match done");
	endtask : t_match
	// Written value differs from both strap and mode-field decodes
	task t_soft;
		apb(1'b1, 12'h000, 32'h00009000);
		wait_status;
		chk("soft", 4'b0100, {speed_100_o, autoneg_en_o, full_duplex_o, power_down_o});
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl_reg", 32'h00001000, rd);
		$display("soft done");
	endtask : t_soft
	task t_pd_exit;
		run_strap(3'h1, 3'h6);
		apb(1'b1, 12'h008, 32'h00000061);
		apb(1'b1, 12'h000, 32'h00008800);
		wait_status;
		chk("wake", 4'b1010, {speed_100_o, autoneg_en_o, full_duplex_o, power_down_o});
		chk("valid", 1, config_valid_o);
		$display("wake done");
	endtask : t_pd_exit
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		wait_oe;
		chk("seed", 0, scrambler_seed_o);
		chk("ctrl", 4'b1110, {speed_100_o, autoneg_en_o, full_duplex_o, power_down_o});
		t_modes;
		t_match;
		t_soft;
		t_pd_exit;
		tally_and_finish;
	end
	initial begin
		#50000;
		fails++;
		tally_and_finish;
	end
endmodule : scl_strap_latch_bench
bind scl_strap_latch scl_strap_latch_props scl_strap_latch_props_inst(.clk_i(clk_i), .rst_n_i(rst_n_i),
	.pin_reset_n_i(pin_reset_n_i), .rx_err_pin_i(rx_err_pin_i), .rx_clk_pin_i(rx_clk_pin_i),
	.rx_data_pin_i(rx_data_pin_i), .col_pin_i(col_pin_i), .rx_data_pin_o(rx_data_pin_o),
	.rx_pins_oe_o(rx_pins_oe_o), .frame_address_i(frame_address_i), .frame_match_o(frame_match_o),
	.scrambler_seed_o(scrambler_seed_o), .power_down_o(power_down_o), .config_valid_o(config_valid_o));

// file: testbench/scl_strap_latch_properties.sv
// Port-level checks of the strap latch
`timescale 1ns/1ns
module scl_strap_latch_props(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic pin_reset_n_i,
	input wire logic rx_err_pin_i,
	input wire logic rx_clk_pin_i,
	input wire logic [3:0] rx_data_pin_i,
	input wire logic col_pin_i,
	input wire logic [3:0] rx_data_pin_o,
	input wire logic rx_pins_oe_o,
	input wire logic [4:0] frame_address_i,
	input wire logic frame_match_o,
	input wire logic [4:0] scrambler_seed_o,
	input wire logic power_down_o,
	input wire logic config_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_held; !pin_reset_n_i ##1 !pin_reset_n_i; endsequence
	sequence s_rel; !pin_reset_n_i ##1 pin_reset_n_i [*3]; endsequence
	property p_por; $rose(rst_n_i) |-> !rx_pins_oe_o; endproperty
	a_por: assert property (p_por) else $error("pads driven at reset exit");
	property p_held; s_held |=> !rx_pins_oe_o; endproperty
	a_held: assert property (p_held) else $error("pads driven in pin reset");
	// Release takes three edges: register, capture, run
	property p_rel; s_rel |-> !rx_pins_oe_o ##1 rx_pins_oe_o; endproperty
	a_rel: assert property (p_rel) else $error("pad drive timing wrong");
	property p_idle; !rx_pins_oe_o |-> rx_data_pin_o == 4'h0; endproperty
	a_idle: assert property (p_idle) else $error("pad output while released");
	property p_match; 1'b1 |-> frame_match_o == (config_valid_o && frame_address_i == scrambler_seed_o); endproperty
	a_match: assert property (p_match) else $error("frame match wrong");
	property p_seed;
		$rose(rx_pins_oe_o) |->
			scrambler_seed_o == {2'b00, $past(rx_data_pin_i[3]), $past(rx_clk_pin_i), $past(rx_err_pin_i)};
	endproperty
	a_seed: assert property (p_seed) else $error("address straps not latched");
	property p_pd;
		$rose(rx_pins_oe_o) |-> power_down_o == ($past(col_pin_i) && $past(rx_data_pin_i[1]) && !$past(rx_data_pin_i[0]));
	endproperty
	a_pd: assert property (p_pd) else $error("power-down strap wrong");
	property p_valid; config_valid_o |-> rx_pins_oe_o; endproperty
	a_valid: assert property (p_valid) else $error("valid before capture");
endmodule : scl_strap_latch_props
